// ==== logic/phy_link_state_adapter.sv ====
// link state adapter between a fabric protocol core and a serial link training engine
// assumes the training engine reports its state each cycle and acts on the ordered-set
// fields, target generation and retrain request driven here; one clock, apb registers
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ns

// Summary of operation
// [RL1] base width 4 bytes, else lane count
// [RL2] data width is base times multiplier times aggregation count
// [RL3] orientation known before equalization starts
// [RL4] every capability supports both orientations here
// [RL5] crosslink result used when enabled
// [RL6] programmed orientation used without crosslink
// [RL7] training states map onto abstract states
// [RL8] core drives control, status returns
// [RL9] advertise modified ordered set support
// [RL10] modified sets carry alternate protocol usage
// [RL11] downstream requests with status zero
// [RL12] upstream answers requested protocol supported
// [RL13] complete exchanges sets with status zero
// [RL14] first gen L0, fifth gen, start data
// [RL15] only symmetric widths 1..32 lanes
// [RL16] no self-test mode exists
// [RL17] retraining goes through recovery
// [RL18] aggregation fixed at build time
// [RL19] one abstraction port per instance
// [RL20] master loopback optional, slave by engine
// [RL21] lane reversal optional, engine rules
// [RL22] clock compensation left to engine
// [RL23] retimers handled by engine rules
// [RL24] sequence number zero, no link retry
// [RL25] abstract state updates within one cycle
module phy_link_state_adapter
  import phy_adapt_pkg::*;
#(
  parameter int LANES = 4,
  parameter int MULT = 1,
  parameter int AGG_COUNT = 1,
  parameter bit MLOOP_SUPPORT = 1'b1,
  parameter bit XLINK_SUPPORT = 1'b1,
  // arbitrary neutral vendor value for the fabric protocol
  parameter logic [15:0] ALT_VENDOR_ID = 16'h5A5A,
  localparam int BASE_BYTES = (LANES <= 4) ? 4 : LANES,
  localparam int DATA_W = 8 * BASE_BYTES * MULT * AGG_COUNT
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire train_state_e TRAIN_STATE,
  input wire logic [2:0] CUR_GEN,
  input wire logic XLINK_DONE,
  input wire logic XLINK_UPSTREAM,
  input wire logic RX_OS_VALID,
  input wire os_fields_s RX_OS,
  output os_fields_s TX_OS,
  output logic [2:0] TARGET_GEN,
  output logic EQ_REQ,
  output logic SDS_REQ,
  output logic RETRAIN_REQ,
  output logic ORIENT_UPSTREAM,
  output logic MASTER_LOOPBACK,
  input wire logic CORE_RETRAIN,
  input wire logic CORE_TX_VALID,
  input wire logic [DATA_W-1:0] CORE_TX_DATA,
  output logic CORE_TX_READY,
  output logic [3:0] CORE_LINK_STATE,
  output logic [3:0] CORE_PREV_STATE,
  output logic TX_TLP_VALID,
  output logic [DATA_W-1:0] TX_TLP_DATA,
  output logic [11:0] TX_TLP_SEQ
);

  // refuse widths and multipliers the data path cannot serve, at elaboration
  if (!(LANES inside {1, 2, 4, 8, 12, 16, 32})) begin : g_bad_lanes // [RL15]
    $error("unsupported lane count");
  end
  if (!(MULT inside {1, 2, 3, 4, 8})) begin : g_bad_mult // [RL2]
    $error("unsupported data multiplier");
  end
  if (AGG_COUNT < 1 || AGG_COUNT > 4) begin : g_bad_agg // [RL18]
    $error("unsupported aggregation count");
  end

  // map one training state onto its abstract code; all others read as down
  function automatic logic [3:0] map_state(input train_state_e ts);
    logic [3:0] code;
    code = LINK_STATE_DOWN;
    case (ts)
      TS_L0: code = LINK_STATE_ACTIVE;
      TS_L1: code = LINK_STATE_LOW_POWER_ONE;
      TS_L2: code = LINK_STATE_LOW_POWER_TWO;
      TS_L3: code = LINK_STATE_LOW_POWER_THREE;
      TS_L0S: code = LINK_STATE_LOW_POWER_FOUR;
      TS_RECOVERY: code = LINK_STATE_RETRAINING;
      default: code = LINK_STATE_DOWN;
    endcase
    return code;
  endfunction : map_state

  // true while the engine sits between link width accept and lane number accept
  function automatic logic in_accept_window(input train_state_e ts);
    return ts inside {TS_CFG_LW_ACCEPT, TS_CFG_LN_WAIT, TS_CFG_LN_ACCEPT};
  endfunction : in_accept_window

  logic [31:0] ctrl_reg;
  logic [3:0] state_reg;
  logic [3:0] prev_reg;
  logic orient_up_reg;
  logic orient_ok_reg;
  logic [1:0] neg_result_reg;
  logic peer_ok_reg;
  logic retrain_reg;
  neg_state_e neg_reg;
  neg_state_e neg_next;
  logic [31:0] rdata_next;
  logic [31:0] prdata_reg;
  logic addr_err;
  logic wr_ctrl;
  logic pkt_allowed;

  // zero wait state slave; any access outside the three words errors out
  assign PREADY = 1'b1;
  assign wr_ctrl = PSEL && PENABLE && PWRITE && (PADDR == CTRL_OFFSET);
  always_comb begin
    rdata_next = 32'h0000_0000;
    addr_err = 1'b0;
    if (PADDR == CTRL_OFFSET) begin
      rdata_next = ctrl_reg;
    end else if (PADDR == STATUS_OFFSET) begin
      rdata_next[STAT_STATE_LSB +: 4] = state_reg; // [RL8]
      rdata_next[STAT_PREV_LSB +: 4] = prev_reg;
      rdata_next[STAT_ORIENT_UP_BIT] = orient_up_reg;
      rdata_next[STAT_ORIENT_OK_BIT] = orient_ok_reg;
      rdata_next[STAT_NEG_LSB +: 2] = neg_result_reg;
      rdata_next[STAT_GEN_LSB +: 3] = CUR_GEN;
    end else if (PADDR == CONFIG_OFFSET) begin
      rdata_next[5:0] = 6'(LANES);
      rdata_next[CFG_BYTES_LSB +: 10] = 10'(DATA_W / 8); // [RL1]
    end else begin
      addr_err = 1'b1;
    end
  end
  // read word captured in the setup phase so the bus sees a flop, not the decode;
  // status moving during the access cycle is reported on the next read
  always_ff @(posedge CLOCK) begin
    if (RST)
      prdata_reg <= 32'h0000_0000;
    else if (PSEL && !PENABLE)
      prdata_reg <= rdata_next;
  end
  assign PRDATA = prdata_reg;
  assign PSLVERR = PSEL && PENABLE && addr_err;

  // control word; the retrain bit self clears once the request is issued
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= 32'h0000_0000;
      ctrl_reg[5:0] <= PWDATA[5:0];
      if (!MLOOP_SUPPORT)
        ctrl_reg[CTRL_MLOOP_BIT] <= 1'b0; // [RL20]
    end else if (retrain_reg) begin
      ctrl_reg[CTRL_RETRAIN_BIT] <= 1'b0;
    end
  end

  // abstract state follows the engine with a single register stage
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_reg <= LINK_STATE_DOWN;
      prev_reg <= LINK_STATE_DOWN;
    end else if (map_state(TRAIN_STATE) != state_reg) begin
      state_reg <= map_state(TRAIN_STATE); // [RL7] [RL25]
      prev_reg <= state_reg;
    end
  end
  assign CORE_LINK_STATE = state_reg; // [RL8]
  assign CORE_PREV_STATE = prev_reg;

  // orientation: crosslink outcome when both sides run it, else the programmed value;
  // every capability accepts both orientations so no combination is refused
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      orient_up_reg <= 1'b0;
      orient_ok_reg <= 1'b0;
    end else if (XLINK_SUPPORT && ctrl_reg[CTRL_XLINK_EN_BIT] && XLINK_DONE) begin
      orient_up_reg <= XLINK_UPSTREAM; // [RL5] [RL4]
      orient_ok_reg <= 1'b1;
    end else if (ctrl_reg[CTRL_ORIENT_VALID_BIT]) begin
      orient_up_reg <= ctrl_reg[CTRL_ORIENT_UP_BIT]; // [RL6] [RL4]
      orient_ok_reg <= 1'b1;
    end else if (TRAIN_STATE == TS_DETECT) begin
      orient_ok_reg <= 1'b0;
    end
  end
  assign ORIENT_UPSTREAM = orient_up_reg;

  // retraining is only ever a request to enter recovery; held one cycle
  always_ff @(posedge CLOCK) begin
    if (RST)
      retrain_reg <= 1'b0;
    else
      retrain_reg <= (CORE_RETRAIN || ctrl_reg[CTRL_RETRAIN_BIT]) && !retrain_reg
        && (TRAIN_STATE == TS_L0); // [RL17] [RL8]
  end
  assign RETRAIN_REQ = retrain_reg;
  // no self-test control exists; master loopback is a plain request to the engine
  assign MASTER_LOOPBACK = MLOOP_SUPPORT && ctrl_reg[CTRL_MLOOP_BIT]; // [RL16] [RL20]

  // partner answer seen in the accept window: downstream wants supported, upstream zero
  always_ff @(posedge CLOCK) begin
    if (RST || TRAIN_STATE == TS_DETECT)
      peer_ok_reg <= 1'b0;
    else if (RX_OS_VALID && RX_OS.mod_ts && in_accept_window(TRAIN_STATE)
        && RX_OS.usage == MOD_TS_USAGE_ALT_PROTO && RX_OS.vendor_id == ALT_VENDOR_ID
        && RX_OS.neg_status == (orient_up_reg ? NEG_STATUS_REQUEST
                                              : NEG_STATUS_SUPPORTED))
      peer_ok_reg <= 1'b1;
  end

  // negotiation and bring-up sequencer
  always_comb begin
    neg_next = neg_reg;
    case (neg_reg)
      NG_IDLE: begin
        if (ctrl_reg[CTRL_NEG_EN_BIT] && orient_ok_reg && in_accept_window(TRAIN_STATE))
          neg_next = NG_TS1; // [RL3]
      end
      NG_TS1: begin
        if (TRAIN_STATE == TS_CFG_COMPLETE)
          neg_next = peer_ok_reg ? NG_TS2 : NG_FAIL;
      end
      NG_TS2: begin
        if (RX_OS_VALID && RX_OS.is_ts2 && RX_OS.neg_status == NEG_STATUS_REQUEST
            && RX_OS.vendor_id == ALT_VENDOR_ID)
          neg_next = NG_WAIT_L0; // [RL13]
        else if (TRAIN_STATE != TS_CFG_COMPLETE)
          neg_next = NG_FAIL;
      end
      NG_WAIT_L0: begin
        if (TRAIN_STATE == TS_L0 && CUR_GEN == GEN_FIRST)
          neg_next = NG_EQ; // [RL14]
      end
      NG_EQ: begin
        if (TRAIN_STATE == TS_L0 && CUR_GEN == GEN_FIFTH)
          neg_next = NG_SDS; // [RL14]
      end
      NG_SDS: neg_next = NG_DATA; // [RL14]
      NG_DATA: begin
        if (TRAIN_STATE inside {TS_DETECT, TS_DISABLED, TS_HOT_RESET})
          neg_next = NG_IDLE;
      end
      NG_FAIL: begin
        if (TRAIN_STATE == TS_DETECT)
          neg_next = NG_IDLE;
      end
      default: neg_next = NG_IDLE;
    endcase
  end

  // sequencer state, reset to idle whenever the engine falls back to detect
  always_ff @(posedge CLOCK) begin
    if (RST)
      neg_reg <= NG_IDLE;
    else if (TRAIN_STATE == TS_DETECT && neg_reg != NG_FAIL)
      neg_reg <= NG_IDLE;
    else
      neg_reg <= neg_next;
  end

  // outcome kept for software until the next negotiation starts
  always_ff @(posedge CLOCK) begin
    if (RST)
      neg_result_reg <= NEG_NONE;
    else if (neg_next == NG_FAIL && neg_reg != NG_FAIL)
      neg_result_reg <= NEG_FAILED;
    else if (neg_next == NG_WAIT_L0 && neg_reg == NG_TS2)
      neg_result_reg <= NEG_OK;
    else if (neg_next == NG_TS1 && neg_reg == NG_IDLE)
      neg_result_reg <= NEG_NONE;
  end

  // ordered-set fields presented to the engine
  always_comb begin
    TX_OS = '0;
    if (ctrl_reg[CTRL_NEG_EN_BIT] && (TRAIN_STATE == TS_POLLING
        || TRAIN_STATE inside {[TS_CFG_LW_START:TS_CFG_IDLE]}))
      TX_OS.ehl = EHL_MOD_TS_SUPPORTED; // [RL9]
    if (neg_reg == NG_TS1) begin
      TX_OS.mod_ts = 1'b1;
      TX_OS.usage = MOD_TS_USAGE_ALT_PROTO; // [RL10]
      TX_OS.vendor_id = ALT_VENDOR_ID;
      TX_OS.neg_status = orient_up_reg ? NEG_STATUS_SUPPORTED // [RL12]
                                       : NEG_STATUS_REQUEST; // [RL11]
    end else if (neg_reg == NG_TS2) begin
      TX_OS.mod_ts = 1'b1;
      TX_OS.is_ts2 = 1'b1;
      TX_OS.usage = MOD_TS_USAGE_ALT_PROTO; // [RL10]
      TX_OS.vendor_id = ALT_VENDOR_ID;
      TX_OS.neg_status = NEG_STATUS_REQUEST; // [RL13]
    end
  end

  // rate target stays first gen until negotiation has passed; equalization needs a
  // resolved orientation or its phases cannot be sequenced
  assign TARGET_GEN = (neg_reg inside {NG_EQ, NG_SDS, NG_DATA}) ? GEN_FIFTH : GEN_FIRST;
  assign EQ_REQ = (neg_reg == NG_EQ) && orient_ok_reg; // [RL3] [RL14]
  assign SDS_REQ = (neg_reg == NG_SDS); // [RL14]

  // packets flow only after start of data and while the link is up
  assign pkt_allowed = (neg_reg == NG_DATA) && (TRAIN_STATE == TS_L0); // [RL14]
  assign CORE_TX_READY = pkt_allowed;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      TX_TLP_VALID <= 1'b0;
      TX_TLP_DATA <= '0;
      TX_TLP_SEQ <= TLP_SEQ_ZERO;
    end else begin
      TX_TLP_VALID <= pkt_allowed && CORE_TX_VALID;
      TX_TLP_SEQ <= TLP_SEQ_ZERO; // [RL24] no retry buffer is kept
      if (pkt_allowed && CORE_TX_VALID)
        TX_TLP_DATA <= CORE_TX_DATA; // [RL19]
    end
  end
  // clock compensation, lane reversal, polarity and retimers are handled by the
  // engine; this block only relays its state [RL21] [RL22] [RL23]

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_neg_passed;
    neg_reg == NG_TS2 ##1 neg_reg == NG_WAIT_L0;
  endsequence

  sequence s_gen_switch;
    neg_reg == NG_EQ && TRAIN_STATE == TS_L0 && CUR_GEN == GEN_FIFTH;
  endsequence

  a_state_map_l0: assert property ( // [RL7]
    TRAIN_STATE == TS_L0 |=> CORE_LINK_STATE == LINK_STATE_ACTIVE)
    else $error("active state not reported after l0");
  a_state_map_rec: assert property ( // [RL25]
    TRAIN_STATE == TS_RECOVERY |=> CORE_LINK_STATE == LINK_STATE_RETRAINING)
    else $error("retraining state late");
  a_state_map_l0s: assert property ( // [RL7]
    TRAIN_STATE == TS_L0S |=> CORE_LINK_STATE == LINK_STATE_LOW_POWER_FOUR)
    else $error("l0s not mapped to low power four");
  a_prev_tracks: assert property ( // [RL8]
    $changed(CORE_LINK_STATE) |-> CORE_PREV_STATE == $past(CORE_LINK_STATE))
    else $error("previous state not captured");
  a_ts1_status: assert property ( // [RL11]
    neg_reg == NG_TS1 && !orient_up_reg |-> TX_OS.neg_status == NEG_STATUS_REQUEST
      && TX_OS.usage == MOD_TS_USAGE_ALT_PROTO && TX_OS.vendor_id == ALT_VENDOR_ID)
    else $error("downstream request fields wrong");
  a_ts1_answer: assert property ( // [RL12]
    neg_reg == NG_TS1 && orient_up_reg |-> TX_OS.neg_status == NEG_STATUS_SUPPORTED)
    else $error("upstream answer status wrong");
  a_ts2_fields: assert property ( // [RL13]
    neg_reg == NG_TS2 |-> TX_OS.is_ts2 && TX_OS.neg_status == NEG_STATUS_REQUEST)
    else $error("complete stage set fields wrong");
  a_gen5_order: assert property ( // [RL14]
    s_neg_passed |-> TARGET_GEN == GEN_FIRST && !SDS_REQ)
    else $error("rate raised before first gen l0");
  a_sds_then_data: assert property ( // [RL14]
    s_gen_switch |=> SDS_REQ ##1 (neg_reg == NG_DATA && !SDS_REQ))
    else $error("start of data sequence broken");
  a_no_pkt_early: assert property ( // [RL14]
    CORE_TX_READY |-> $past(neg_reg) inside {NG_SDS, NG_DATA})
    else $error("packets allowed before start of data");
  a_seq_zero: assert property ( // [RL24]
    TX_TLP_VALID |-> TX_TLP_SEQ == TLP_SEQ_ZERO)
    else $error("nonzero sequence number");
  a_retrain_pulse: assert property ( // [RL17]
    RETRAIN_REQ |-> $past(TRAIN_STATE) == TS_L0 ##1 !RETRAIN_REQ)
    else $error("retrain request outside l0 or held");
  a_orient_prog: assert property ( // [RL6]
    ctrl_reg[CTRL_ORIENT_VALID_BIT] && !ctrl_reg[CTRL_XLINK_EN_BIT]
      |=> orient_ok_reg && ORIENT_UPSTREAM == $past(ctrl_reg[CTRL_ORIENT_UP_BIT]))
    else $error("programmed orientation not applied");

endmodule : phy_link_state_adapter

// ==== logic/phy_adapt_pkg.sv ====
// constants, encodings and carrier structs for the link state adapter
// assumes one core clock domain; the training engine sits outside this block
package phy_adapt_pkg;

  // apb register byte addresses and control reset value
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] CONFIG_OFFSET = 8'h08;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0020;

  // control register bit positions
  localparam int CTRL_ORIENT_VALID_BIT = 0;
  localparam int CTRL_ORIENT_UP_BIT = 1;
  localparam int CTRL_XLINK_EN_BIT = 2;
  localparam int CTRL_RETRAIN_BIT = 3;
  localparam int CTRL_MLOOP_BIT = 4;
  localparam int CTRL_NEG_EN_BIT = 5;

  // status and config register field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_PREV_LSB = 4;
  localparam int STAT_ORIENT_UP_BIT = 8;
  localparam int STAT_ORIENT_OK_BIT = 9;
  localparam int STAT_NEG_LSB = 10;
  localparam int STAT_GEN_LSB = 12;
  localparam int CFG_BYTES_LSB = 8;

  // abstract link state codes seen by the core
  localparam logic [3:0] LINK_STATE_DOWN = 4'h0;
  localparam logic [3:0] LINK_STATE_ACTIVE = 4'h1;
  localparam logic [3:0] LINK_STATE_RETRAINING = 4'h2;
  localparam logic [3:0] LINK_STATE_LOW_POWER_ONE = 4'h7;
  localparam logic [3:0] LINK_STATE_LOW_POWER_TWO = 4'h8;
  localparam logic [3:0] LINK_STATE_LOW_POWER_THREE = 4'h9;
  localparam logic [3:0] LINK_STATE_LOW_POWER_FOUR = 4'hA;

  // ordered-set field values used during alternate protocol negotiation
  localparam logic [1:0] EHL_MOD_TS_SUPPORTED = 2'h3;
  localparam logic [2:0] MOD_TS_USAGE_ALT_PROTO = 3'h2;
  localparam logic [1:0] NEG_STATUS_REQUEST = 2'h0;
  localparam logic [1:0] NEG_STATUS_SUPPORTED = 2'h2;

  // negotiation outcome reported in status
  localparam logic [1:0] NEG_NONE = 2'h0;
  localparam logic [1:0] NEG_OK = 2'h1;
  localparam logic [1:0] NEG_FAILED = 2'h2;

  // transfer generations and the fixed packet sequence number
  localparam logic [2:0] GEN_FIRST = 3'h0;
  localparam logic [2:0] GEN_THIRD = 3'h2;
  localparam logic [2:0] GEN_FIFTH = 3'h4;
  localparam logic [11:0] TLP_SEQ_ZERO = 12'h000;

  // training states as reported by the training engine
  typedef enum logic [4:0] {
    TS_DETECT = 5'h00, TS_POLLING = 5'h01, TS_CFG_LW_START = 5'h02,
    TS_CFG_LW_ACCEPT = 5'h03, TS_CFG_LN_WAIT = 5'h04, TS_CFG_LN_ACCEPT = 5'h05,
    TS_CFG_COMPLETE = 5'h06, TS_CFG_IDLE = 5'h07, TS_L0 = 5'h08, TS_L0S = 5'h09,
    TS_L1 = 5'h0A, TS_L2 = 5'h0B, TS_L3 = 5'h0C, TS_RECOVERY = 5'h0D,
    TS_DISABLED = 5'h0E, TS_LOOPBACK = 5'h0F, TS_HOT_RESET = 5'h10
  } train_state_e;

  // negotiation and bring-up sequencer
  typedef enum logic [2:0] {
    NG_IDLE = 3'h0, NG_TS1 = 3'h1, NG_TS2 = 3'h2, NG_WAIT_L0 = 3'h3,
    NG_EQ = 3'h4, NG_SDS = 3'h5, NG_DATA = 3'h6, NG_FAIL = 3'h7
  } neg_state_e;

  // ordered-set fields driven to or received from the training engine
  typedef struct packed {
    logic mod_ts;
    logic is_ts2;
    logic [1:0] ehl;
    logic [2:0] usage;
    logic [1:0] neg_status;
    logic [15:0] vendor_id;
  } os_fields_s;

endpackage : phy_adapt_pkg

// ==== dv/train_engine_model.sv ====
// partner model: remote training engine that follows the bench's state commands
// assumes cmd_valid is a one-edge pulse; answers modified ordered sets after DELAY cycles
`timescale 1ns/1ns
module train_engine_model
  import phy_adapt_pkg::*;
#(
  parameter int DELAY = 3,
  parameter logic [15:0] VENDOR = 16'h5A5A  // arbitrary neutral value
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire train_state_e cmd_state,
  input wire logic mute,
  input wire os_fields_s tx_os,
  input wire logic [2:0] target_gen,
  input wire logic eq_req,
  input wire logic retrain_req,
  input wire logic orient_up,
  output train_state_e train_state,
  output logic [2:0] cur_gen,
  output logic rx_valid,
  output os_fields_s rx_os
);
  logic [3:0] wait_reg;

  // bench steers the state; a retrain request wins and forces recovery
  always_ff @(posedge clock) begin
    if (rst) begin
      train_state <= TS_DETECT;
    end else if (retrain_req) begin
      train_state <= TS_RECOVERY;
    end else if (cmd_valid) begin
      train_state <= cmd_state;
    end
  end

  // rate rises only once equalization is asked for, detect drops it back
  always_ff @(posedge clock) begin
    if (rst || train_state == TS_DETECT) begin
      cur_gen <= GEN_FIRST;
    end else if (eq_req && target_gen == GEN_FIFTH) begin
      cur_gen <= GEN_FIFTH;
    end
  end

  // reply delay, so the adapter must not expect an answer at once
  always_ff @(posedge clock) begin
    if (rst || !tx_os.mod_ts) begin
      wait_reg <= '0;
    end else if (wait_reg != 4'hF) begin
      wait_reg <= wait_reg + 4'h1;
    end
  end

  // peer answer; when silent the lines toggle so stale data never looks valid
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_os <= '0;
    end else if (!mute && tx_os.mod_ts && wait_reg >= DELAY) begin
      rx_valid <= 1'b1;
      rx_os <= '{mod_ts: 1'b1, is_ts2: tx_os.is_ts2, ehl: EHL_MOD_TS_SUPPORTED,
                 usage: MOD_TS_USAGE_ALT_PROTO, vendor_id: VENDOR,
                 neg_status: (tx_os.is_ts2 || orient_up) ?
                   NEG_STATUS_REQUEST : NEG_STATUS_SUPPORTED};
    end else begin
      rx_valid <= 1'b0;
      rx_os <= ~rx_os;
    end
  end
endmodule : train_engine_model

// ==== dv/phy_link_state_adapter_test.sv ====
// bench for the link state adapter: apb tasks, state commands, packet sends
// assumes the partner model stands in for the training engine
`timescale 1ns/1ns
module phy_link_state_adapter_test
  import phy_adapt_pkg::*;
();
  localparam int LANES = 8;
  localparam int MULT = 2;
  localparam int DW = 8 * LANES * MULT;  // base is the lane count above four lanes
  localparam logic [15:0] VENDOR = 16'h5A5A;  // arbitrary neutral value
  logic clock = 0;
  logic rst = 1;
  logic psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, xlink_done = 0, xlink_up = 0, core_retrain = 0, core_valid = 0;
  logic [DW-1:0] core_data = '0, tlp_data;
  logic cmd_valid = 0, mute = 0, rx_valid, eq_req, sds_req, retrain_req, orient_up, mloop;
  logic core_ready, tlp_valid;
  logic [11:0] tlp_seq;
  logic [2:0] cur_gen, target_gen;
  logic [3:0] link_state, prev_state, prev;
  train_state_e cmd_state = TS_DETECT, train_state;
  os_fields_s rx_os, tx_os;
  int n_fail = 0, checked = 0;
  train_state_e map_st[9] = '{TS_L0, TS_L1, TS_L2, TS_L3, TS_L0S, TS_RECOVERY, TS_DISABLED,
                              TS_L0, TS_LOOPBACK};
  logic [3:0] map_code[9] = '{LINK_STATE_ACTIVE, LINK_STATE_LOW_POWER_ONE,
    LINK_STATE_LOW_POWER_TWO, LINK_STATE_LOW_POWER_THREE, LINK_STATE_LOW_POWER_FOUR,
    LINK_STATE_RETRAINING, LINK_STATE_DOWN, LINK_STATE_ACTIVE, LINK_STATE_DOWN};

  phy_link_state_adapter #(.LANES(LANES), .MULT(MULT), .ALT_VENDOR_ID(VENDOR))
  phy_link_state_adapter_i (
    .CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TRAIN_STATE(train_state), .CUR_GEN(cur_gen), .XLINK_DONE(xlink_done),
    .XLINK_UPSTREAM(xlink_up), .RX_OS_VALID(rx_valid), .RX_OS(rx_os), .TX_OS(tx_os),
    .TARGET_GEN(target_gen), .EQ_REQ(eq_req), .SDS_REQ(sds_req), .RETRAIN_REQ(retrain_req),
    .ORIENT_UPSTREAM(orient_up), .MASTER_LOOPBACK(mloop), .CORE_RETRAIN(core_retrain),
    .CORE_TX_VALID(core_valid), .CORE_TX_DATA(core_data), .CORE_TX_READY(core_ready),
    .CORE_LINK_STATE(link_state), .CORE_PREV_STATE(prev_state), .TX_TLP_VALID(tlp_valid),
    .TX_TLP_DATA(tlp_data), .TX_TLP_SEQ(tlp_seq));

  train_engine_model #(.VENDOR(VENDOR)) train_engine_model_i (
    .clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd_state(cmd_state), .mute(mute),
    .tx_os(tx_os), .target_gen(target_gen), .eq_req(eq_req), .retrain_req(retrain_req),
    .orient_up(orient_up), .train_state(train_state), .cur_gen(cur_gen),
    .rx_valid(rx_valid), .rx_os(rx_os));

  // free-running core clock, 40 ns
  initial begin
    forever #20 clock = ~clock;
  end

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic go(input train_state_e s);
    @(posedge clock);
    cmd_valid <= 1;
    cmd_state <= s;
    @(posedge clock);
    cmd_valid <= 0;
  endtask : go

  task automatic wn(input int n);
    repeat (n) @(negedge clock);
  endtask : wn

  task automatic see_retrain;
    for (int n = 0; n < 8 && retrain_req !== 1'b1; n++) @(negedge clock);
    chk(retrain_req, 1'b1);
    @(negedge clock);
    chk(retrain_req, 1'b0);
  endtask : see_retrain

  task automatic send(input logic [DW-1:0] d);
    @(posedge clock);
    core_valid <= 1;
    core_data <= d;
    @(posedge clock);
    core_valid <= 0;
    @(negedge clock);
    chk(tlp_valid, 1'b1);
    chk(tlp_data, d);
    chk(tlp_seq, TLP_SEQ_ZERO);
  endtask : send

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    test_done;
  end

  initial begin
    repeat (5) @(posedge clock);
    rst <= 0;
    apb(0, CTRL_OFFSET, '0);
    chk(rd, CTRL_RESET);
    apb(1, STATUS_OFFSET, 32'hFFFF_FFFF);
    apb(0, STATUS_OFFSET, '0);
    chk(rd, 32'h0000_0000);
    apb(0, CONFIG_OFFSET, '0);
    chk(rd, (32'(DW / 8) << CFG_BYTES_LSB) | 32'(LANES));
    apb(0, 8'h0C, '0);
    chk({err, rd}, {1'b1, 32'h0000_0000});
    $display("test registers done");
    prev = LINK_STATE_DOWN;
    for (int i = 0; i < 9; i++) begin
      go(map_st[i]);
      @(negedge clock);
      chk(link_state, prev);
      @(negedge clock);
      chk(link_state, map_code[i]);
      chk(prev_state, prev);
      prev = map_code[i];
    end
    $display("test state map done");
    go(TS_DETECT);
    apb(1, CTRL_OFFSET, 32'h0000_0021);  // programmed downstream, negotiation on
    go(TS_POLLING);
    wn(2);
    chk(tx_os.ehl, EHL_MOD_TS_SUPPORTED);
    go(TS_CFG_LW_ACCEPT);
    wn(2);
    chk({tx_os.mod_ts, tx_os.usage}, {1'b1, MOD_TS_USAGE_ALT_PROTO});
    chk({tx_os.neg_status, tx_os.vendor_id}, {NEG_STATUS_REQUEST, VENDOR});
    go(TS_CFG_LN_WAIT);
    go(TS_CFG_LN_ACCEPT);
    go(TS_CFG_COMPLETE);
    wn(2);
    chk({tx_os.is_ts2, tx_os.neg_status}, {1'b1, NEG_STATUS_REQUEST});
    wn(2);
    go(TS_CFG_IDLE);
    go(TS_L0);
    for (int n = 0; n < 20 && eq_req !== 1'b1; n++) @(negedge clock);
    chk({eq_req, target_gen, core_ready}, {1'b1, GEN_FIFTH, 1'b0});
    chk(orient_up, 1'b0);
    for (int n = 0; n < 20 && sds_req !== 1'b1; n++) @(negedge clock);
    chk(sds_req, 1'b1);
    @(negedge clock);
    chk({sds_req, core_ready}, 2'b01);
    for (int i = 0; i < 2; i++) send({4{32'(i) ^ 32'hC3C3_5A5A}});
    apb(0, STATUS_OFFSET, '0);
    chk(rd[14:8], {GEN_FIFTH, NEG_OK, 2'b10});
    $display("test negotiation done");
    apb(1, CTRL_OFFSET, 32'h0000_0039);  // retrain and master loopback
    see_retrain;
    chk(mloop, 1'b1);
    wn(3);
    chk({link_state, core_ready}, {LINK_STATE_RETRAINING, 1'b0});
    apb(0, CTRL_OFFSET, '0);
    chk(rd, 32'h0000_0031);
    go(TS_L0);
    @(posedge clock);
    core_retrain <= 1;
    @(posedge clock);
    core_retrain <= 0;
    see_retrain;
    $display("test retrain done");
    go(TS_DETECT);
    apb(1, CTRL_OFFSET, 32'h0000_0024);  // crosslink on, nothing programmed
    mute <= 1;
    go(TS_CFG_LW_ACCEPT);
    wn(2);
    chk(tx_os.mod_ts, 1'b0);
    @(posedge clock);
    xlink_done <= 1;
    xlink_up <= 1;
    wn(4);
    chk(orient_up, 1'b1);
    chk({tx_os.neg_status, tx_os.vendor_id}, {NEG_STATUS_SUPPORTED, VENDOR});
    go(TS_CFG_COMPLETE);
    wn(3);
    apb(0, STATUS_OFFSET, '0);
    chk(rd[11:8], {NEG_FAILED, 2'b11});
    $display("test crosslink done");
    test_done;
  end
endmodule : phy_link_state_adapter_test
